// ---- core/csil_loader.sv ----
// configuration image loader: walks the upper image entries and distributes them
//
// Functional notes
// - The byte at entry 0Fh becomes bits 11:8 of the gpio wake polarity field.
// - Entry 10h gives the full-speed and entry 11h the high-speed interrupt polling interval.
// - Four 32-bit flag words are built lsb first from four entries each starting at 13h, 17h, 1Bh and 1Fh.
// - Five string pointers, each a byte length then a word offset, are read from 25h to 2Eh in order.
// - The object store block length comes from 2Fh and its word offset from 30h.
// - High-speed device descriptor pointer sits at 35h/36h and config-plus-interface at 37h/38h.
// - Full-speed device descriptor pointer sits at 39h/3Ah and config-plus-interface at 3Bh/3Ch.
// - Wake frame filter 0 data length is at 3Dh and offset at 3Eh, and a used length is 20 bytes.
// - Of the filter data the first four bytes fill the filter config register and the next 16 the mask.
// - Test bus input length is at 41h and offset at 42h, and a used length is 4 bytes.
// - The software descriptor length comes from 46h and its offset from 47h.
// - A zero length entry leaves that item at its hardware default; on a reload the loader keeps the value from the previous load instead.
// - A first byte other than A5h means no programmed image and the load fails.
// - Every image offset counts 16-bit words, so the byte address is twice the offset.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "csil_cfg.svh"

module csil_loader
   import csil_pkg::*;
#(
   parameter logic [3:0]   POL_DEFAULT   = 4'h0,     // wake polarity 11:8 default
   parameter logic [7:0]   FS_DEFAULT    = 8'h00,    // full-speed interval default
   parameter logic [7:0]   HS_DEFAULT    = 8'h00,    // high-speed interval default
   parameter logic [127:0] FLAGS_DEFAULT = 128'h0,   // flag words default
   parameter logic [87:0]  DESC_DEFAULT  = 88'h0,    // pointer lengths/offsets default
   parameter logic [31:0]  WFF_CFG_DEF   = 32'h0,    // filter 0 config default
   parameter logic [127:0] WFF_MASK_DEF  = 128'h0,   // filter 0 mask default
   parameter logic [31:0]  TB_DEFAULT    = 32'h0     // test bus input default
) (
   input  wire logic         pclk,                      // core clock, 250 MHz
   input  wire logic         presetn,                   // async reset, low active
   input  wire logic         psel,                      // apb select
   input  wire logic         penable,                   // apb access phase
   input  wire logic         pwrite,                    // apb direction
   input  wire logic [7:0]   paddr,                     // apb byte address
   input  wire logic [31:0]  pwdata,                    // apb write data
   output logic      [31:0]  prdata,                    // apb read data
   output logic              pready,                    // apb ready
   output logic              pslverr,                   // apb error
   output logic              mem_rd_req,                // image byte wanted
   output csil_addr_t        mem_rd_addr,               // image byte address
   input  wire logic         mem_rd_ack,                // image byte delivered
   input  wire logic [7:0]   mem_rd_data,               // image byte value
   output logic      [3:0]   gpio_wake_polarity_field,  // polarity bits 11:8
   output logic      [7:0]   poll_fs,                   // full-speed interval
   output logic      [7:0]   poll_hs,                   // high-speed interval
   output logic      [127:0] cfg_flags,                 // flag words 0..3
   output logic      [87:0]  desc_len,                  // byte lengths per slot
   output logic      [87:0]  desc_off,                  // word offsets per slot
   output logic      [31:0]  wake_filter_config_reg,    // filter 0 config
   output logic      [127:0] wake_filter_mask_reg,      // filter 0 byte mask
   output logic      [31:0]  test_bus_in,               // test bus input data
   output logic              load_busy,                 // load in progress
   output logic              load_done,                 // load finished pulse
   output logic              load_fail                  // load failed pulse
);

   csil_state_t state;
   csil_state_t next_state;
   logic        start_pend;
   logic        reload;
   logic        take;
   logic [4:0]  cnt;
   logic [7:0]  wff_len;
   logic [7:0]  wff_off;
   logic [7:0]  tb_len;
   logic [7:0]  tb_off;
   logic        len_nz;
   logic [5:0]  slot_info;
   logic [31:0] poll_word;

   // pointer decode: {valid, is_length, slot}
   function automatic logic [5:0] desc_slot(input csil_addr_t a);
      csil_addr_t d;
      desc_slot = 6'h00;
      d = 9'h000;
      if (a >= `CSIL_A_STR_LO && a <= `CSIL_A_BOS_HI) begin
         d = a - `CSIL_A_STR_LO;
         desc_slot = {1'b1, ~d[0], d[4:1]};
      end else if (a >= `CSIL_A_DSC_LO && a <= `CSIL_A_DSC_HI) begin
         d = a - `CSIL_A_DSC_LO;
         desc_slot = {1'b1, ~d[0], d[4:1] + `CSIL_SLOT_DSC};
      end else if (a == `CSIL_A_SW_LEN || a == `CSIL_A_SW_OFF) begin
         desc_slot = {1'b1, a == `CSIL_A_SW_LEN, `CSIL_SLOT_SW};
      end
   endfunction

   // word offset to byte address
   function automatic csil_addr_t word_addr(input logic [7:0] off);
      word_addr = {off, 1'b0};
   endfunction

   assign take      = mem_rd_req & mem_rd_ack;
   assign slot_info = desc_slot(mem_rd_addr);
   assign poll_word = {12'h000, gpio_wake_polarity_field, poll_hs, poll_fs};

   csil_apb_regs u_regs (
      .pclk      (pclk),
      .presetn   (presetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .busy      (load_busy),
      .done      (load_done),
      .fail      (load_fail),
      .poll_word (poll_word),
      .flags     (cfg_flags),
      .reload    (reload)
   );

   // a load runs once after reset, then per reload; a reload while busy is queued
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_pend <= 1'b1;
      end else begin
         start_pend <= reload | (start_pend & (state != CSIL_IDLE));
      end
   end

   // sequence: marker, header walk, then optional filter and test bus payloads
   always_comb begin
      next_state = state;
      case (state)
         CSIL_IDLE: begin
            if (start_pend) next_state = CSIL_MARK;
         end
         CSIL_MARK: begin
            if (take) next_state = (mem_rd_data == `CSIL_MARKER) ? CSIL_HDR : CSIL_IDLE;
         end
         CSIL_HDR: begin
            if (take && mem_rd_addr == `CSIL_A_SW_OFF) begin
               if (wff_len != 8'h00)     next_state = CSIL_WFF;
               else if (tb_len != 8'h00) next_state = CSIL_TBUS;
               else                      next_state = CSIL_IDLE;
            end
         end
         CSIL_WFF: begin
            if (take && cnt == `CSIL_WFF_BYTES - 5'h01)
               next_state = (tb_len != 8'h00) ? CSIL_TBUS : CSIL_IDLE;
         end
         CSIL_TBUS: begin
            if (take && cnt == `CSIL_TB_BYTES - 5'h01) next_state = CSIL_IDLE;
         end
         default: next_state = CSIL_IDLE;
      endcase
   end

   // state register and status pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= CSIL_IDLE;
         load_busy <= 1'b0;
         load_done <= 1'b0;
         load_fail <= 1'b0;
      end else begin
         state     <= next_state;
         load_busy <= (next_state != CSIL_IDLE);
         load_done <= (state != CSIL_IDLE) && (state != CSIL_MARK) && (next_state == CSIL_IDLE);
         load_fail <= (state == CSIL_MARK) && (next_state == CSIL_IDLE);
      end
   end

   // read request stays up through a state; address steps after each byte taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_rd_req  <= 1'b0;
         mem_rd_addr <= `CSIL_A_MARK;
         cnt         <= 5'h00;
      end else begin
         mem_rd_req <= (next_state != CSIL_IDLE);
         if (next_state != state) begin
            cnt <= 5'h00;
            case (next_state)
               CSIL_MARK: mem_rd_addr <= `CSIL_A_MARK;
               CSIL_HDR:  mem_rd_addr <= `CSIL_A_WAKE_POL;
               CSIL_WFF:  mem_rd_addr <= word_addr(wff_off);
               CSIL_TBUS: mem_rd_addr <= word_addr(tb_off);
               default:   mem_rd_addr <= mem_rd_addr;
            endcase
         end else if (take) begin
            cnt         <= cnt + 5'h01;
            mem_rd_addr <= mem_rd_addr + 9'h001;
         end
      end
   end

   // single-byte settings; reserved entries pass by untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_wake_polarity_field <= POL_DEFAULT;
         poll_fs                  <= FS_DEFAULT;
         poll_hs                  <= HS_DEFAULT;
      end else if (take && state == CSIL_HDR) begin
         case (mem_rd_addr)
            `CSIL_A_WAKE_POL: gpio_wake_polarity_field <= mem_rd_data[3:0];
            `CSIL_A_POLL_FS:  poll_fs <= mem_rd_data;
            `CSIL_A_POLL_HS:  poll_hs <= mem_rd_data;
            default:          poll_fs <= poll_fs;
         endcase
      end
   end

   // flag words, lsb first; entries run contiguous so one byte index covers all four
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_flags <= FLAGS_DEFAULT;
      end else if (take && state == CSIL_HDR && mem_rd_addr >= `CSIL_A_FLAGS_LO
                   && mem_rd_addr <= `CSIL_A_FLAGS_HI) begin
         cfg_flags[{4'(mem_rd_addr - `CSIL_A_FLAGS_LO), 3'b000} +: 8] <= mem_rd_data;
      end
   end

   // pointer pairs: a zero length keeps both the current length and offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         desc_len <= DESC_DEFAULT;
         desc_off <= DESC_DEFAULT;
         len_nz   <= 1'b0;
      end else if (take && state == CSIL_HDR && slot_info[5]) begin
         if (slot_info[4]) begin
            len_nz <= (mem_rd_data != 8'h00);
            if (mem_rd_data != 8'h00)
               desc_len[{slot_info[3:0], 3'b000} +: 8] <= mem_rd_data;
         end else if (len_nz) begin
            desc_off[{slot_info[3:0], 3'b000} +: 8] <= mem_rd_data;
         end
      end
   end

   // payload pointers; lengths cleared at each start so a stale length never triggers a fetch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wff_len <= 8'h00;
         wff_off <= 8'h00;
         tb_len  <= 8'h00;
         tb_off  <= 8'h00;
      end else if (state == CSIL_MARK) begin
         wff_len <= 8'h00;
         tb_len  <= 8'h00;
      end else if (take && state == CSIL_HDR) begin
         case (mem_rd_addr)
            `CSIL_A_WFF_LEN: wff_len <= mem_rd_data;
            `CSIL_A_WFF_OFF: wff_off <= mem_rd_data;
            `CSIL_A_TB_LEN:  tb_len  <= mem_rd_data;
            `CSIL_A_TB_OFF:  tb_off  <= mem_rd_data;
            default:         wff_off <= wff_off;
         endcase
      end
   end

   // filter 0 payload; fixed 20 bytes fetched whatever nonzero length is stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_filter_config_reg <= WFF_CFG_DEF;
         wake_filter_mask_reg   <= WFF_MASK_DEF;
      end else if (take && state == CSIL_WFF) begin
         if (cnt < `CSIL_WFF_CFG_BYTES)
            wake_filter_config_reg[{cnt[1:0], 3'b000} +: 8] <= mem_rd_data;
         else
            wake_filter_mask_reg[{4'(cnt - `CSIL_WFF_CFG_BYTES), 3'b000} +: 8] <= mem_rd_data;
      end
   end

   // test bus input payload, lsb first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_bus_in <= TB_DEFAULT;
      end else if (take && state == CSIL_TBUS) begin
         test_bus_in[{cnt[1:0], 3'b000} +: 8] <= mem_rd_data;
      end
   end

   // checks
   a_marker_reject: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_MARK && take && mem_rd_data != `CSIL_MARKER) |=> (load_fail && state == CSIL_IDLE && !load_done))
      else $error("bad marker did not fail the load");

   a_done_single: assert property (@(posedge pclk) disable iff (!presetn)
      load_done |=> (!load_done && (!load_busy || $past(start_pend | reload))))
      else $error("done pulse longer than one cycle");

   a_idle_stable: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_IDLE && !start_pend) |=> ($stable(cfg_flags) && $stable(desc_off) && $stable(test_bus_in)))
      else $error("settings moved outside a load");

   a_wake_pol_load: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_HDR && take && mem_rd_addr == `CSIL_A_WAKE_POL)
      |=> gpio_wake_polarity_field == $past(mem_rd_data[3:0]))
      else $error("wake polarity not loaded");

   a_poll_intervals: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_HDR && take && mem_rd_addr == `CSIL_A_POLL_HS) |=> (poll_hs == $past(mem_rd_data)
      && poll_fs == $past(poll_fs)))
      else $error("high-speed interval not loaded");

   a_flags_order: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_HDR && take && mem_rd_addr == `CSIL_A_FLAGS_HI) |=> cfg_flags[127:120] == $past(mem_rd_data))
      else $error("last flag byte misplaced");

   a_zero_len_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_HDR && take && slot_info[5] && slot_info[4] && mem_rd_data == 8'h00) |=> $stable(desc_len))
      else $error("zero length item was overwritten");

   a_zero_len_off: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_HDR && take && slot_info[5] && !slot_info[4] && !len_nz) |=> $stable(desc_off))
      else $error("offset of absent item was overwritten");

   a_word_offset: assert property (@(posedge pclk) disable iff (!presetn)
      (state != CSIL_WFF && next_state == CSIL_WFF) |=> (mem_rd_addr == {wff_off, 1'b0} && mem_rd_req))
      else $error("filter fetch not at word offset");

   a_filter_cfg: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_WFF && take && cnt == 5'h03) |=> wake_filter_config_reg[31:24] == $past(mem_rd_data))
      else $error("filter config top byte misplaced");

   a_test_bus: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_TBUS && take && cnt == 5'h03) |=> (test_bus_in[31:24] == $past(mem_rd_data)
      && state == CSIL_IDLE && load_done))
      else $error("test bus payload did not finish the load");

   a_filter_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_WFF && take && cnt == 5'h13) |=> wake_filter_mask_reg[127:120] == $past(mem_rd_data))
      else $error("filter mask top byte misplaced");

   a_tbus_offset: assert property (@(posedge pclk) disable iff (!presetn)
      (state != CSIL_TBUS && next_state == CSIL_TBUS) |=> (mem_rd_addr == {tb_off, 1'b0} && mem_rd_req))
      else $error("test bus fetch not at word offset");

   a_sw_length: assert property (@(posedge pclk) disable iff (!presetn)
      (state == CSIL_HDR && take && mem_rd_addr == `CSIL_A_SW_LEN && mem_rd_data != 8'h00)
      |=> desc_len[87:80] == $past(mem_rd_data))
      else $error("software descriptor length not loaded");

endmodule // csil_loader

// ---- include/csil_cfg.svh ----
// image layout, register map and field positions of the configuration image loader
`ifndef CSIL_CFG_SVH
`define CSIL_CFG_SVH

// image byte positions (one stored byte per entry)
`define CSIL_MARKER        8'ha5
`define CSIL_A_MARK        9'h000
`define CSIL_A_WAKE_POL    9'h00f
`define CSIL_A_POLL_FS     9'h010
`define CSIL_A_POLL_HS     9'h011
`define CSIL_A_FLAGS_LO    9'h013
`define CSIL_A_FLAGS_HI    9'h022
`define CSIL_A_STR_LO      9'h025
`define CSIL_A_BOS_HI      9'h030
`define CSIL_A_DSC_LO      9'h035
`define CSIL_A_DSC_HI      9'h03c
`define CSIL_A_WFF_LEN     9'h03d
`define CSIL_A_WFF_OFF     9'h03e
`define CSIL_A_TB_LEN      9'h041
`define CSIL_A_TB_OFF      9'h042
`define CSIL_A_SW_LEN      9'h046
`define CSIL_A_SW_OFF      9'h047

// pointer slots: 0-4 strings, 5 object store, 6-9 device/config, 10 software
`define CSIL_SLOT_DSC      4'h6
`define CSIL_SLOT_SW       4'ha
`define CSIL_DESC_N        11

// payload sizes in bytes
`define CSIL_WFF_BYTES     5'h14
`define CSIL_WFF_CFG_BYTES 5'h04
`define CSIL_TB_BYTES      5'h04

// register byte offsets
`define CSIL_R_CTRL        8'h00
`define CSIL_R_STATUS      8'h04
`define CSIL_R_POLL        8'h08
`define CSIL_R_FLAGS0      8'h10
`define CSIL_R_FLAGS1      8'h14
`define CSIL_R_FLAGS2      8'h18
`define CSIL_R_FLAGS3      8'h1c

// field positions
`define CSIL_CTRL_RELOAD   0
`define CSIL_ST_BUSY       0
`define CSIL_ST_LOADED     1
`define CSIL_ST_FAILED     2
`define CSIL_POLL_FS_LSB   0
`define CSIL_POLL_HS_LSB   8
`define CSIL_POLL_POL_LSB  16

`endif

// ---- include/csil_pkg.sv ----
// types shared by the configuration image loader
package csil_pkg;

   // loader sequence states
   typedef enum logic [2:0] {
      CSIL_IDLE = 3'b000,
      CSIL_MARK = 3'b001,
      CSIL_HDR  = 3'b010,
      CSIL_WFF  = 3'b011,
      CSIL_TBUS = 3'b100
   } csil_state_t;

   // byte address into the image memory
   typedef logic [8:0] csil_addr_t;

endpackage

// ---- core/csil_apb_regs.sv ----
// apb register slave of the configuration image loader
`timescale 1ns/1ps
`include "csil_cfg.svh"

module csil_apb_regs
   import csil_pkg::*;
(
   input  wire logic         pclk,        // core clock
   input  wire logic         presetn,     // async reset, low active
   input  wire logic         psel,        // apb select
   input  wire logic         penable,     // apb access phase
   input  wire logic         pwrite,      // apb direction
   input  wire logic [7:0]   paddr,       // apb byte address
   input  wire logic [31:0]  pwdata,      // apb write data
   output logic      [31:0]  prdata,      // apb read data
   output logic              pready,      // apb ready
   output logic              pslverr,     // apb error
   input  wire logic         busy,        // load in progress
   input  wire logic         done,        // load finished pulse
   input  wire logic         fail,        // load failed pulse
   input  wire logic [31:0]  poll_word,   // packed polling and polarity view
   input  wire logic [127:0] flags,       // configuration flag words
   output logic              reload       // reload request pulse
);

   logic loaded;
   logic failed;
   logic setup_hit;
   logic mapped;
   logic [31:0] rd_mux;

   // one wait state: ready follows the first access cycle
   assign setup_hit = psel & penable & ~pready;

   // read decode; unmapped offsets answer with an error
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `CSIL_R_CTRL:   rd_mux = 32'h0000_0000;
         `CSIL_R_STATUS: begin
            rd_mux[`CSIL_ST_BUSY]   = busy;
            rd_mux[`CSIL_ST_LOADED] = loaded;
            rd_mux[`CSIL_ST_FAILED] = failed;
         end
         `CSIL_R_POLL:   rd_mux = poll_word;
         `CSIL_R_FLAGS0: rd_mux = flags[31:0];
         `CSIL_R_FLAGS1: rd_mux = flags[63:32];
         `CSIL_R_FLAGS2: rd_mux = flags[95:64];
         `CSIL_R_FLAGS3: rd_mux = flags[127:96];
         default:        mapped = 1'b0;
      endcase
   end

   // bus answer registered, valid with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_hit;
         prdata  <= (setup_hit && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr <= setup_hit & ~mapped;
      end
   end

   // write takes effect only at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload <= 1'b0;
      end else begin
         reload <= psel & penable & pready & pwrite & (paddr == `CSIL_R_CTRL) & pwdata[`CSIL_CTRL_RELOAD];
      end
   end

   // sticky outcome; a new reload clears, a same-cycle outcome wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded <= 1'b0;
         failed <= 1'b0;
      end else begin
         loaded <= done | (loaded & ~reload);
         failed <= fail | (failed & ~reload);
      end
   end

endmodule // csil_apb_regs

// ---- tb/csil_mem_model.sv ----
// image memory model answering the loader's byte reads
`timescale 1ns/1ps
module csil_mem_model (
   input  wire logic       pclk,     // core clock
   input  wire logic       rd_req,   // byte wanted
   input  wire logic [8:0] rd_addr,  // byte address
   input  wire logic [3:0] lat,      // idle cycles before answer
   output logic            rd_ack,   // byte delivered
   output logic      [7:0] rd_data   // byte value
);
   logic [7:0] img [512];
   logic [3:0] cnt;
   initial begin
      rd_ack = 1'b0;
      rd_data = 8'h3c;
      cnt = 4'h0;
   end
   // one ack per address; data toggles while nothing is offered so stale bytes never match
   always @(posedge pclk) begin
      if (rd_ack || !rd_req) begin
         rd_ack <= 1'b0;
         cnt <= 4'h0;
         rd_data <= ~rd_data;
      end else if (cnt >= lat) begin
         rd_ack <= 1'b1;
         rd_data <= img[rd_addr];
      end else begin
         cnt <= cnt + 4'h1;
         rd_data <= ~rd_data;
      end
   end
endmodule // csil_mem_model

// ---- tb/csil_loader_tb.sv ----
// self-checking bench for the configuration image loader
`timescale 1ns/1ps
module csil_loader_tb;
   import csil_pkg::*;
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0]   paddr = 8'h00, mem_rd_data, poll_fs, poll_hs;
   logic [31:0]  pwdata = 32'h0, prdata, wake_filter_config_reg, test_bus_in, rd;
   logic         pready, pslverr, mem_rd_req, mem_rd_ack, load_busy, load_done, load_fail;
   csil_addr_t   mem_rd_addr;
   logic [3:0]   gpio_wake_polarity_field, lat = 4'h0;
   logic [127:0] cfg_flags, wake_filter_mask_reg;
   logic [87:0]  desc_len, desc_off;
   int           n_fail = 0, num_checks = 0, cyc = 0;
   always #2 pclk = ~pclk;
   csil_loader dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
      .gpio_wake_polarity_field(gpio_wake_polarity_field), .poll_fs(poll_fs), .poll_hs(poll_hs),
      .cfg_flags(cfg_flags), .desc_len(desc_len), .desc_off(desc_off),
      .wake_filter_config_reg(wake_filter_config_reg), .wake_filter_mask_reg(wake_filter_mask_reg),
      .test_bus_in(test_bus_in), .load_busy(load_busy), .load_done(load_done), .load_fail(load_fail));
   csil_mem_model mem_u (.pclk(pclk), .rd_req(mem_rd_req), .rd_addr(mem_rd_addr), .lat(lat),
      .rd_ack(mem_rd_ack), .rd_data(mem_rd_data));
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen high at a rising edge, no wait count assumed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // image with reserved entries as a well-behaved writer leaves them
   task automatic fill(input logic [7:0] k, input logic [7:0] mark, input logic [7:0] tlen, input logic [7:0] swl);
      for (int i = 0; i < 512; i++) mem_u.img[i] = 8'(i) ^ k;
      for (int a = 0; a < 'h58; a++)
         if (a == 'h12 || (a >= 'h31 && a <= 'h34) || a == 'h3f || a == 'h40 || a == 'h43 || a == 'h45 || a >= 'h50)
            mem_u.img[a] = 8'h00;
      mem_u.img['h44] = 8'h02;
      mem_u.img[0] = mark;
      mem_u.img['h3d] = 8'h14;
      mem_u.img['h3e] = 8'h60;
      mem_u.img['h41] = tlen;
      mem_u.img['h42] = 8'h70;
      mem_u.img['h46] = swl;
   endtask
   // end of a load: one outcome pulse, then request and pulse gone
   task automatic wait_end(input logic bad);
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      do begin
         @(negedge pclk);
         n++;
         seen |= load_busy;
      end while (load_done !== 1'b1 && load_fail !== 1'b1 && n < 2000);
      chk({seen, load_done, load_fail, mem_rd_req, load_busy}, {1'b1, ~bad, bad, 2'b00});
      @(negedge pclk);
      chk({load_done, load_fail, mem_rd_req}, 3'b000);
   endtask
   // every setting against the bytes of the current image
   task automatic check_all(input logic tb_used, input logic sw_used);
      logic [7:0] b [512];
      int a;
      b = mem_u.img;
      chk(gpio_wake_polarity_field, b['h0f][3:0]);
      chk({poll_hs, poll_fs}, {b['h11], b['h10]});
      for (int i = 0; i < 16; i++) chk(cfg_flags[8*i +: 8], b['h13 + i]);
      for (int s = 0; s < 11; s++) begin
         a = s < 5 ? 'h25 + 2 * s : s == 5 ? 'h2f : s < 10 ? 'h35 + 2 * (s - 6) : 'h46;
         chk({desc_off[8*s +: 8], desc_len[8*s +: 8]}, (s == 10 && !sw_used) ? 16'h0 : {b[a + 1], b[a]});
      end
      for (int i = 0; i < 20; i++)
         chk(i < 4 ? wake_filter_config_reg[8*i +: 8] : wake_filter_mask_reg[8*(i-4) +: 8], b['hc0 + i]);
      for (int i = 0; i < 4; i++) chk(test_bus_in[8*i +: 8], tb_used ? b['he0 + i] : 8'h00);
   endtask
   // hang guard well above the longest slow load
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      fill(8'h00, 8'ha5, 8'h00, 8'h00);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wait_end(1'b0);
      check_all(1'b0, 1'b0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, {12'h0, mem_u.img['h0f][3:0], mem_u.img['h11], mem_u.img['h10]});
      apb(1'b0, 8'h0c, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[2:0], 3'b010);
      // slow memory reload with the test bus payload present
      lat <= 4'h3;
      fill(8'h5c, 8'ha5, 8'h04, 8'h03);
      apb(1'b1, 8'h00, 32'h1);
      wait_end(1'b0);
      check_all(1'b1, 1'b1);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, {mem_u.img['h22], mem_u.img['h21], mem_u.img['h20], mem_u.img['h1f]});
      // filter length zero: filter keeps its bytes, test bus payload follows the header directly
      mem_u.img['h3d] = 8'h00;
      mem_u.img['hc0] = 8'hff;
      mem_u.img['he0] = 8'h11;
      apb(1'b1, 8'h00, 32'h1);
      wait_end(1'b0);
      mem_u.img['hc0] = 8'h9c;
      check_all(1'b1, 1'b1);
      // blank memory: load fails and settings stay put
      mem_u.img[0] = 8'h5a;
      apb(1'b1, 8'h00, 32'h1);
      wait_end(1'b1);
      check_all(1'b1, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[2:0], 3'b100);
      end_sim;
   end
endmodule // csil_loader_tb
